// [move_reverse_packed_add_alu.sv]
/*
 * execution slice for moves, inverted moves, move-top, byte and bit
 * reversal and signed packed (halving) additions, with the program status
 * flags held here. one operation is taken per cycle; its result and write
 * strobe appear one cycle later.
 * assumes the decoder has already evaluated the condition code, formed the
 * flexible second operand and its shifter carry, and supplies the current
 * destination value for move-top.
 */
`timescale 1ns/1ns

// Notes on behaviour
// (RULE1) flag-setting move or inverted move sets negative and zero from the written value
// (RULE2) flag-setting moves take carry from the second-operand shifter when it makes one
// (RULE3) flag-setting moves keep the overflow flag unchanged
// (RULE4) inverted move writes the complement of the second operand
// (RULE5) move-top loads immediate into bits 31..16 and keeps bits 15..0
// (RULE6) move-top never changes any flag
// (RULE7) low immediate move then move-top to one register builds any 32-bit constant
// (RULE8) word byte reverse swaps byte 0 with 3 and byte 1 with 2
// (RULE9) halfword byte reverse swaps bytes inside each halfword only
// (RULE10) signed halfword reverse swaps low halfword bytes and sign-extends
// (RULE11) bit reverse puts operand bit 31 minus i in result bit i
// (RULE12) reverses, packed adds and packed halving adds leave all flags unchanged
// (RULE13) packed halfword add does two separate signed halfword additions
// (RULE14) packed byte add does four separate signed byte additions
// (RULE15) each lane sum goes to its own lane with no carry between lanes
// (RULE16) halving halfword add halves each full-precision lane sum
// (RULE17) halving byte add halves each of the four byte lane sums
// (RULE18) exchange halving operations use destination and two sources, conditionally executed
// (RULE19) add-sub exchange: top gets (a.top+b.bot)/2, bottom gets (a.bot-b.top)/2
// (RULE20) sub-add exchange: bottom gets (a.top-b.bot)/2, top gets (a.bot+b.top)/2
// (RULE21) software never names stack pointer or program counter for reversals
// (RULE22) a failed condition leaves the destination and every flag unchanged
// (RULE23) halving uses arithmetic shift of a one-bit-wider sum, immune to overflow
module move_reverse_packed_add_alu
(
    input  wire logic                                         clk,
    input  wire logic                                         nrst,
    input  wire logic                                         op_valid,
    input  wire move_reverse_packed_add_alu_pkg::op_code_t    op_code,
    input  wire logic                                         cond_pass,
    input  wire logic                                         set_flags,
    input  wire logic [move_reverse_packed_add_alu_pkg::WORD_W-1:0]  first_source_register,
    input  wire logic [move_reverse_packed_add_alu_pkg::WORD_W-1:0]  second_source_register,
    input  wire logic [move_reverse_packed_add_alu_pkg::HALF_W-1:0]  sixteen_bit_immediate,
    input  wire logic [move_reverse_packed_add_alu_pkg::WORD_W-1:0]  dest_current,
    input  wire logic [move_reverse_packed_add_alu_pkg::INDEX_W-1:0] dest_index,
    input  wire logic                                         shifter_carry_valid,
    input  wire logic                                         shifter_carry,
    output logic                                              wr_en_reg,
    output logic [move_reverse_packed_add_alu_pkg::INDEX_W-1:0]      wr_index_reg,
    output logic [move_reverse_packed_add_alu_pkg::WORD_W-1:0]       wr_data_reg,
    output logic [move_reverse_packed_add_alu_pkg::FLAG_W-1:0]       program_status_flags
);
    import move_reverse_packed_add_alu_pkg::*;

    logic [WORD_W-1:0]  a;
    logic [WORD_W-1:0]  b;
    logic [WORD_W-1:0]  rev_word;
    logic [WORD_W-1:0]  rev_half;
    logic [WORD_W-1:0]  rev_signed;
    logic [WORD_W-1:0]  rev_bits;
    logic [WORD_W-1:0]  add16_res;
    logic [WORD_W-1:0]  hadd16_res;
    logic [WORD_W-1:0]  add8_res;
    logic [WORD_W-1:0]  hadd8_res;
    logic [WORD_W-1:0]  hasx_res;
    logic [WORD_W-1:0]  hsax_res;
    logic [WORD_W-1:0]  result;
    logic               op_known;
    logic               fire;
    logic               is_move_flag;
    logic [FLAG_W-1:0]  flags_reg;
    logic [FLAG_W-1:0]  flags_next;
    logic               wr_en_next;
    logic [WORD_W-1:0]  wr_data_next;
    logic [INDEX_W-1:0] wr_index_next;

    assign a = first_source_register;
    assign b = second_source_register;

    // reversals read the single register operand, the first source
    assign rev_word = {a[7:0], a[15:8], a[23:16], a[31:24]};                 // see RULE8
    assign rev_half = {a[23:16], a[31:24], a[7:0], a[15:8]};                 // see RULE9
    assign rev_signed = {{HALF_W{a[7]}}, a[7:0], a[15:8]};                   // see RULE10

    genvar gi;
    generate
        for (gi = 0; gi < WORD_W; gi++)
        begin : g_bit_rev
            assign rev_bits[gi] = a[WORD_W-1-gi];                            // see RULE11
        end

        // one extra bit per lane keeps the full sum; lanes never share a carry
        for (gi = 0; gi < 2; gi++)
        begin : g_half_lane
            logic [HALF_W:0] sum;
            assign sum = {a[HALF_W*gi+HALF_W-1], a[HALF_W*gi +: HALF_W]}
                       + {b[HALF_W*gi+HALF_W-1], b[HALF_W*gi +: HALF_W]};    // see RULE13
            assign add16_res[HALF_W*gi +: HALF_W] = sum[HALF_W-1:0];         // see RULE15
            assign hadd16_res[HALF_W*gi +: HALF_W] = sum[HALF_W:1];          // see RULE16
        end

        for (gi = 0; gi < 4; gi++)
        begin : g_byte_lane
            logic [BYTE_W:0] sum;
            assign sum = {a[BYTE_W*gi+BYTE_W-1], a[BYTE_W*gi +: BYTE_W]}
                       + {b[BYTE_W*gi+BYTE_W-1], b[BYTE_W*gi +: BYTE_W]};    // see RULE14
            assign add8_res[BYTE_W*gi +: BYTE_W] = sum[BYTE_W-1:0];          // see RULE15
            assign hadd8_res[BYTE_W*gi +: BYTE_W] = sum[BYTE_W:1];           // see RULE17
        end
    endgenerate

    // exchange lanes: 17-bit sums and differences, then drop bit 0
    logic [HALF_W:0] asx_top;
    logic [HALF_W:0] asx_bot;
    logic [HALF_W:0] sax_top;
    logic [HALF_W:0] sax_bot;

    assign asx_top = {a[31], a[31:16]} + {b[15], b[15:0]};                   // see RULE19
    assign asx_bot = {a[15], a[15:0]} - {b[31], b[31:16]};                   // see RULE19
    assign sax_bot = {a[31], a[31:16]} - {b[15], b[15:0]};                   // see RULE20
    assign sax_top = {a[15], a[15:0]} + {b[31], b[31:16]};                   // see RULE20
    // bit HALF_W of each sum is the true sign, so the halved value cannot wrap
    assign hasx_res = {asx_top[HALF_W:1], asx_bot[HALF_W:1]};                // see RULE23
    assign hsax_res = {sax_top[HALF_W:1], sax_bot[HALF_W:1]};                // see RULE23

    assign result =
        (op_code == op_move)                      ? b :
        (op_code == op_move_wide)                 ? {{HALF_W{1'b0}}, sixteen_bit_immediate} :
        (op_code == op_move_inverted)             ? ~b :                     // see RULE4
        (op_code == op_move_top_halfword)         ? {sixteen_bit_immediate,
                                                     dest_current[HALF_W-1:0]} : // see RULE5
        (op_code == op_byte_reverse_word)         ? rev_word :
        (op_code == op_byte_reverse_each_half)    ? rev_half :
        (op_code == op_byte_reverse_signed_half)  ? rev_signed :
        (op_code == op_bit_reverse_word)          ? rev_bits :
        (op_code == op_packed_signed_add_halves)  ? add16_res :
        (op_code == op_packed_signed_add_bytes)   ? add8_res :
        (op_code == op_packed_halving_add_halves) ? hadd16_res :
        (op_code == op_packed_halving_add_bytes)  ? hadd8_res :
        (op_code == op_halving_add_sub_exchange)  ? hasx_res :
        (op_code == op_halving_sub_add_exchange)  ? hsax_res :
        RESULT_RESET;

    // unknown encodings are dropped rather than writing a garbage value
    assign op_known = (op_code inside {op_move, op_move_wide, op_move_inverted,
                       op_move_top_halfword, op_byte_reverse_word,
                       op_byte_reverse_each_half, op_byte_reverse_signed_half,
                       op_bit_reverse_word, op_packed_signed_add_halves,
                       op_packed_signed_add_bytes, op_packed_halving_add_halves,
                       op_packed_halving_add_bytes, op_halving_add_sub_exchange,
                       op_halving_sub_add_exchange});

    assign fire = op_valid && cond_pass && op_known;                         // see RULE22 RULE18
    // the wide immediate form has no flag-setting variant
    assign is_move_flag = fire && set_flags
                        && (op_code == op_move || op_code == op_move_inverted);

    assign flags_next[FLAG_N_POS] = is_move_flag ? result[WORD_W-1]
                                                 : flags_reg[FLAG_N_POS];    // see RULE1
    assign flags_next[FLAG_Z_POS] = is_move_flag ? (result == RESULT_RESET)
                                                 : flags_reg[FLAG_Z_POS];    // see RULE1
    assign flags_next[FLAG_C_POS] = (is_move_flag && shifter_carry_valid) ? shifter_carry
                                                 : flags_reg[FLAG_C_POS];    // see RULE2
    assign flags_next[FLAG_V_POS] = flags_reg[FLAG_V_POS];                   // see RULE3 RULE6 RULE12

    assign wr_en_next = fire;
    // a failed condition holds the last data so nothing downstream toggles
    assign wr_data_next = fire ? result : wr_data_reg;                       // see RULE22
    assign wr_index_next = fire ? dest_index : wr_index_reg;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wr_en_reg    <= 1'b0;
            wr_data_reg  <= RESULT_RESET;
            wr_index_reg <= INDEX_RESET;
            flags_reg    <= FLAGS_RESET;
        end
        else
        begin
            wr_en_reg    <= wr_en_next;
            wr_data_reg  <= wr_data_next;
            wr_index_reg <= wr_index_next;
            flags_reg    <= flags_next;
        end
    end

    assign program_status_flags = flags_reg;

    // helper copies of the inputs and flags for the checks below
    logic [WORD_W-1:0] a_q;
    logic [WORD_W-1:0] b_q;
    logic [FLAG_W-1:0] flags_q;

    always_ff @(posedge clk)
    begin
        a_q     <= a;
        b_q     <= b;
        flags_q <= flags_reg;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence took(op_code_t o);
        op_valid && cond_pass && op_code == o;
    endsequence

    chk_move_nz_flags: assert property (                                     // see RULE1
        (op_valid && cond_pass && set_flags
         && (op_code == op_move || op_code == op_move_inverted))
        |=> flags_reg[FLAG_N_POS] == wr_data_reg[WORD_W-1]
            && flags_reg[FLAG_Z_POS] == (wr_data_reg == 32'h0000_0000))
        else $error("move flags do not follow written value");

    chk_move_carry: assert property (                                        // see RULE2
        (op_valid && cond_pass && set_flags && shifter_carry_valid
         && (op_code == op_move || op_code == op_move_inverted))
        |=> flags_reg[FLAG_C_POS] == $past(shifter_carry))
        else $error("move carry not taken from shifter");

    chk_v_steady: assert property (                                          // see RULE3
        ##1 program_status_flags[FLAG_V_POS] == flags_q[FLAG_V_POS])
        else $error("overflow flag changed");

    chk_inv_data: assert property (                                          // see RULE4
        took(op_move_inverted) |=> wr_en_reg && wr_data_reg == ~b_q)
        else $error("inverted move data wrong");

    chk_top_halves: assert property (                                        // see RULE5
        took(op_move_top_halfword)
        |=> wr_data_reg == {$past(sixteen_bit_immediate), $past(dest_current[15:0])})
        else $error("move-top halves wrong");

    chk_quiet_flags: assert property (                                       // see RULE6 RULE12
        (op_valid && !(op_code == op_move || op_code == op_move_inverted))
        |=> program_status_flags == $past(program_status_flags))
        else $error("flags changed by a flag-neutral operation");

    chk_rev_word: assert property (                                          // see RULE8
        took(op_byte_reverse_word)
        |=> wr_data_reg == {a_q[7:0], a_q[15:8], a_q[23:16], a_q[31:24]})
        else $error("word byte reverse wrong");

    chk_rev_half: assert property (                                          // see RULE9
        took(op_byte_reverse_each_half)
        |=> wr_data_reg[31:16] == {a_q[23:16], a_q[31:24]}
            && wr_data_reg[15:0] == {a_q[7:0], a_q[15:8]})
        else $error("halfword byte reverse wrong");

    chk_rev_signed: assert property (                                        // see RULE10
        took(op_byte_reverse_signed_half)
        |=> wr_data_reg[15:0] == {a_q[7:0], a_q[15:8]}
            && wr_data_reg[31:16] == {16{a_q[7]}})
        else $error("signed halfword reverse wrong");

    chk_bit_rev: assert property (                                           // see RULE11
        took(op_bit_reverse_word)
        |=> wr_data_reg[0] == a_q[31] && wr_data_reg[31] == a_q[0]
            && wr_data_reg[12] == a_q[19])
        else $error("bit reverse wrong");

    chk_add16_lanes: assert property (                                       // see RULE13 RULE15
        took(op_packed_signed_add_halves)
        |=> wr_data_reg[31:16] == 16'(a_q[31:16] + b_q[31:16])
            && wr_data_reg[15:0] == 16'(a_q[15:0] + b_q[15:0]))
        else $error("packed halfword add wrong");

    chk_add8_lanes: assert property (                                        // see RULE14 RULE15
        took(op_packed_signed_add_bytes)
        |=> wr_data_reg[15:8] == 8'(a_q[15:8] + b_q[15:8])
            && wr_data_reg[7:0] == 8'(a_q[7:0] + b_q[7:0]))
        else $error("packed byte add wrong");

    chk_hadd16_lane: assert property (                                       // see RULE16 RULE23
        took(op_packed_halving_add_halves)
        |=> $signed(wr_data_reg[31:16])
            == 16'(($signed({a_q[31], a_q[31:16]}) + $signed({b_q[31], b_q[31:16]})) >>> 1))
        else $error("halving halfword add wrong");

    chk_hadd8_lane: assert property (                                        // see RULE17
        took(op_packed_halving_add_bytes)
        |=> wr_data_reg[31:24] == 8'(({a_q[31], a_q[31:24]} + {b_q[31], b_q[31:24]}) >> 1))
        else $error("halving byte add wrong");

    chk_hasx_lanes: assert property (                                        // see RULE19
        took(op_halving_add_sub_exchange)
        |=> wr_data_reg[31:16] == 16'(({a_q[31], a_q[31:16]} + {b_q[15], b_q[15:0]}) >> 1)
            && wr_data_reg[15:0] == 16'(({a_q[15], a_q[15:0]} - {b_q[31], b_q[31:16]}) >> 1))
        else $error("add-sub exchange wrong");

    chk_hsax_lanes: assert property (                                        // see RULE20
        took(op_halving_sub_add_exchange)
        |=> wr_data_reg[15:0] == 16'(({a_q[31], a_q[31:16]} - {b_q[15], b_q[15:0]}) >> 1)
            && wr_data_reg[31:16] == 16'(({a_q[15], a_q[15:0]} + {b_q[31], b_q[31:16]}) >> 1))
        else $error("sub-add exchange wrong");

    chk_cond_fail: assert property (                                         // see RULE22
        (op_valid && !cond_pass)
        |=> !wr_en_reg && $stable(wr_data_reg) && $stable(program_status_flags))
        else $error("failed condition had an effect");

    cov_const_pair: cover property (                                         // see RULE7
        (op_valid && cond_pass && op_code == op_move_wide)
        ##1 (op_valid && cond_pass && op_code == op_move_top_halfword
             && dest_index == wr_index_reg));
    cov_flag_move: cover property (
        op_valid && cond_pass && op_code == op_move_inverted
        && set_flags && shifter_carry_valid);
    cov_hadd_overflow: cover property (
        op_valid && cond_pass && op_code == op_packed_halving_add_halves
        && a[31] == b[31] && add16_res[31] != a[31]);
    cov_cond_skip: cover property (op_valid && !cond_pass ##1 op_valid && cond_pass);

endmodule : move_reverse_packed_add_alu

// [move_reverse_packed_add_alu_pkg.sv]
/*
 * shared constants and the operation encoding for the move, reverse and
 * packed add datapath slice.
 * assumes the decoder presents one operation per cycle in the core clock domain.
 */
package move_reverse_packed_add_alu_pkg;

    localparam int unsigned WORD_W = 32;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FLAG_W = 4;
    localparam int unsigned INDEX_W = 4;
    localparam int unsigned OP_W = 4;

    // positions of the condition flags inside the flag vector
    localparam int unsigned FLAG_N_POS = 3;
    localparam int unsigned FLAG_Z_POS = 2;
    localparam int unsigned FLAG_C_POS = 1;
    localparam int unsigned FLAG_V_POS = 0;

    localparam logic [FLAG_W-1:0]  FLAGS_RESET = 4'h0;
    localparam logic [WORD_W-1:0]  RESULT_RESET = 32'h0000_0000;
    localparam logic [INDEX_W-1:0] INDEX_RESET = 4'h0;

    typedef enum logic [OP_W-1:0] {
        op_move                   = 4'h0,
        op_move_wide              = 4'h1,
        op_move_inverted          = 4'h3,
        op_move_top_halfword      = 4'h2,
        op_byte_reverse_word      = 4'h6,
        op_byte_reverse_each_half = 4'h7,
        op_byte_reverse_signed_half = 4'h5,
        op_bit_reverse_word       = 4'h4,
        op_packed_signed_add_halves = 4'hC,
        op_packed_signed_add_bytes  = 4'hD,
        op_packed_halving_add_halves = 4'hF,
        op_packed_halving_add_bytes  = 4'hE,
        op_halving_add_sub_exchange  = 4'hA,
        op_halving_sub_add_exchange  = 4'hB
    } op_code_t;

endpackage : move_reverse_packed_add_alu_pkg

// [move_reverse_packed_add_alu_tb_top.sv]
/*
 * self-checking bench for the move, reverse and packed add slice: a driver
 * presents operations and queues expected writes, a monitor compares them.
 * assumes the one-cycle write latency and flag layout of the package.
 */
`timescale 1ns/1ns

module move_reverse_packed_add_alu_tb_top;
    import move_reverse_packed_add_alu_pkg::*;

    typedef struct packed
    {
        logic [WORD_W-1:0]  data;
        logic [INDEX_W-1:0] index;
        logic [FLAG_W-1:0]  flags;
    } note_t;

    logic                clk;
    logic                nrst;
    logic                op_valid;
    op_code_t            op_code;
    logic                cond_pass;
    logic                set_flags;
    logic [WORD_W-1:0]   first_source_register;
    logic [WORD_W-1:0]   second_source_register;
    logic [HALF_W-1:0]   sixteen_bit_immediate;
    logic [WORD_W-1:0]   dest_current;
    logic [INDEX_W-1:0]  dest_index;
    logic                shifter_carry_valid;
    logic                shifter_carry;
    logic                wr_en_reg;
    logic [INDEX_W-1:0]  wr_index_reg;
    logic [WORD_W-1:0]   wr_data_reg;
    logic [FLAG_W-1:0]   program_status_flags;
    note_t               notes[$];
    note_t               n_seen;
    logic [FLAG_W-1:0]   flags_model;
    logic [INDEX_W-1:0]  idx_cnt;
    logic [WORD_W-1:0]   r_a;
    logic [WORD_W-1:0]   r_b;
    logic [HALF_W-1:0]   r_imm;
    int                  err_total;
    int                  checks;
    op_code_t            ops [14] = '{op_move, op_move_wide, op_move_inverted,
        op_move_top_halfword, op_byte_reverse_word, op_byte_reverse_each_half,
        op_byte_reverse_signed_half, op_bit_reverse_word, op_packed_signed_add_halves,
        op_packed_signed_add_bytes, op_packed_halving_add_halves,
        op_packed_halving_add_bytes, op_halving_add_sub_exchange,
        op_halving_sub_add_exchange};

    move_reverse_packed_add_alu i_dut
    (
        .clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
        .cond_pass(cond_pass), .set_flags(set_flags),
        .first_source_register(first_source_register),
        .second_source_register(second_source_register),
        .sixteen_bit_immediate(sixteen_bit_immediate), .dest_current(dest_current),
        .dest_index(dest_index), .shifter_carry_valid(shifter_carry_valid),
        .shifter_carry(shifter_carry), .wr_en_reg(wr_en_reg), .wr_index_reg(wr_index_reg),
        .wr_data_reg(wr_data_reg), .program_status_flags(program_status_flags)
    );

    always #5 clk = ~clk;

    // halving through a one-bit-wider sum so lane overflow cannot flip the sign
    function automatic logic [HALF_W-1:0] half_lane(input logic [15:0] x, input logic [15:0] y,
                                                    input logic sub);
        logic [16:0] s;
        s = sub ? ({x[15], x} - {y[15], y}) : ({x[15], x} + {y[15], y});
        return s[16:1];
    endfunction : half_lane

    function automatic logic [BYTE_W-1:0] byte_lane(input logic [7:0] x, input logic [7:0] y);
        logic [8:0] s;
        s = {x[7], x} + {y[7], y};
        return s[8:1];
    endfunction : byte_lane

    function automatic logic [WORD_W-1:0] model(input op_code_t op, input logic [31:0] a,
        input logic [31:0] b, input logic [15:0] imm, input logic [31:0] dcur);
        logic [31:0] r;
        r = '0;
        case (op)
            op_move:                      r = b;
            op_move_wide:                 r = {16'h0000, imm};
            op_move_inverted:             r = ~b;
            op_move_top_halfword:         r = {imm, dcur[15:0]};
            op_byte_reverse_word:         r = {a[7:0], a[15:8], a[23:16], a[31:24]};
            op_byte_reverse_each_half:    r = {a[23:16], a[31:24], a[7:0], a[15:8]};
            op_byte_reverse_signed_half:  r = {{16{a[7]}}, a[7:0], a[15:8]};
            op_bit_reverse_word:          for (int i = 0; i < 32; i++) r[i] = a[31-i];
            op_packed_signed_add_halves:  r = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
            op_packed_signed_add_bytes:   for (int k = 0; k < 4; k++)
                                              r[8*k+:8] = a[8*k+:8] + b[8*k+:8];
            op_packed_halving_add_halves: r = {half_lane(a[31:16], b[31:16], 1'b0),
                                               half_lane(a[15:0], b[15:0], 1'b0)};
            op_packed_halving_add_bytes:  for (int k = 0; k < 4; k++)
                                              r[8*k+:8] = byte_lane(a[8*k+:8], b[8*k+:8]);
            op_halving_add_sub_exchange:  r = {half_lane(a[31:16], b[15:0], 1'b0),
                                               half_lane(a[15:0], b[31:16], 1'b1)};
            op_halving_sub_add_exchange:  r = {half_lane(a[15:0], b[31:16], 1'b0),
                                               half_lane(a[31:16], b[15:0], 1'b1)};
            default:                      r = '0;
        endcase
        return r;
    endfunction : model

    task automatic chk(input string what, input logic [WORD_W-1:0] seen,
                       input logic [WORD_W-1:0] want);
        checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : chk

    task automatic conclude;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic do_op(input op_code_t op, input logic cp, input logic sf, input logic [31:0] a,
        input logic [31:0] b, input logic [15:0] imm, input logic [31:0] dcur,
        input logic cv, input logic cy);
        note_t n;
        @(posedge clk);
        #1;
        op_valid = 1'b1;
        op_code = op;
        cond_pass = cp;
        set_flags = sf;
        first_source_register = a;
        second_source_register = b;
        sixteen_bit_immediate = imm;
        dest_current = dcur;
        shifter_carry_valid = cv;
        shifter_carry = cy;
        idx_cnt = idx_cnt + 4'h1;
        // stack pointer and program counter numbers are never named as destination
        if (idx_cnt >= 4'hD)
            idx_cnt = 4'h0;
        dest_index = idx_cnt;
        // skipped or unknown operations queue nothing: they make no write, so a note would be unmatched
        if (cp && op !== op_code_t'(4'h8) && op !== op_code_t'(4'h9))
        begin
            n.data = model(op, a, b, imm, dcur);
            if (sf && (op == op_move || op == op_move_inverted))
            begin
                flags_model[FLAG_N_POS] = n.data[31];
                flags_model[FLAG_Z_POS] = (n.data == 32'h0000_0000);
                if (cv)
                    flags_model[FLAG_C_POS] = cy;
            end
            n.index = idx_cnt;
            n.flags = flags_model;
            notes.push_back(n);
        end
    endtask : do_op

    always @(negedge clk)
    begin
        if (nrst === 1'b1 && wr_en_reg !== 1'b0)
        begin
            if (notes.size() == 0)
                chk("unexpected write", 32'h0000_0001, 32'h0000_0000);
            else
            begin
                n_seen = notes.pop_front();
                chk("result", wr_data_reg, n_seen.data);
                chk("index", 32'(wr_index_reg), 32'(n_seen.index));
                chk("flags", 32'(program_status_flags), 32'(n_seen.flags));
            end
        end
    end

    initial
    begin
        #20000;
        err_total++;
        conclude();
    end

    initial
    begin
        clk = 1'b0; nrst = 1'b0; op_valid = 1'b0; op_code = op_move; cond_pass = 1'b0;
        set_flags = 1'b0; first_source_register = '0; second_source_register = '0;
        sixteen_bit_immediate = '0; dest_current = '0; dest_index = '0;
        shifter_carry_valid = 1'b0; shifter_carry = 1'b0; flags_model = FLAGS_RESET;
        idx_cnt = INDEX_RESET; err_total = 0; checks = 0;
        void'($urandom(66));
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk("reset result", wr_data_reg, RESULT_RESET);
        chk("reset flags", 32'(program_status_flags), 32'(FLAGS_RESET));
        do_op(op_move_inverted, 1, 1, 0, 32'h0000_000F, 0, 0, 0, 0);
        do_op(op_move, 1, 1, 0, 32'h0000_0000, 0, 0, 1, 1);
        do_op(op_move, 1, 0, 0, 32'h8000_0000, 0, 0, 1, 0);
        do_op(op_move_inverted, 1, 1, 0, 32'hFFFF_FFFF, 0, 0, 1, 0);
        do_op(op_move, 1, 1, 0, 32'h8000_0000, 0, 0, 0, 1);
        do_op(op_move_inverted, 0, 1, 0, 32'h0000_0000, 0, 0, 1, 1);
        do_op(op_code_t'(4'h8), 1, 1, 0, 32'h0000_0000, 0, 0, 1, 1);
        do_op(op_move_wide, 1, 1, 0, 0, 16'h5678, 0, 1, 1);
        do_op(op_move_top_halfword, 1, 1, 0, 0, 16'h1234, 32'h0000_5678, 1, 1);
        do_op(op_halving_sub_add_exchange, 0, 0, 32'h7FFF_8000, 32'h8000_7FFF, 0, 0, 0, 0);
        do_op(op_packed_signed_add_bytes, 1, 1, 32'h7F7F_80FF, 32'h0101_FF01, 0, 0, 1, 1);
        do_op(op_packed_signed_add_halves, 1, 0, 32'h7FFF_FFFF, 32'h0001_0001, 0, 0, 0, 0);
        do_op(op_packed_halving_add_halves, 1, 0, 32'h7FFF_8000, 32'h7FFF_8000, 0, 0, 0, 0);
        do_op(op_packed_halving_add_bytes, 1, 0, 32'h7F80_7F80, 32'h7F80_0180, 0, 0, 0, 0);
        do_op(op_halving_add_sub_exchange, 1, 0, 32'h7FFF_8000, 32'h8000_7FFF, 0, 0, 0, 0);
        do_op(op_halving_sub_add_exchange, 1, 0, 32'h7FFF_8000, 32'h8000_7FFF, 0, 0, 0, 0);
        for (int j = 0; j < 120; j++)
        begin
            r_a = $urandom;
            r_b = $urandom;
            r_imm = 16'($urandom);
            do_op(ops[$urandom_range(13, 0)], 1'($urandom_range(3, 0) != 0),
                  1'($urandom), r_a, r_b, r_imm, $urandom, 1'($urandom), 1'($urandom));
        end
        @(posedge clk);
        #1;
        op_valid = 1'b0;
        repeat (3) @(posedge clk);
        chk("pending writes", 32'(notes.size()), 32'h0000_0000);
        conclude();
    end

endmodule : move_reverse_packed_add_alu_tb_top
